//--- common/scg_pkg.sv
package scg_pkg;
    localparam int unsigned SCG_DATA_W = 32;
    localparam int unsigned SCG_ADDR_W = 12;
    localparam int unsigned SCG_UNITS = 10;

    // Block base in the system map; only the low address bits are decoded here
    localparam logic [31:0] SCG_BLOCK_BASE = 32'h400f_e000;

    localparam logic [SCG_ADDR_W-1:0] SCG_SLEEP_OFS = 12'h114;
    localparam logic [SCG_ADDR_W-1:0] SCG_DEEP_OFS = 12'h124;
    localparam logic [SCG_ADDR_W-1:0] SCG_STATUS_OFS = 12'h140;
    localparam logic [SCG_ADDR_W-1:0] SCG_MASK_OFS = 12'h144;

    // Writable gate bits; 31:27, 23:19, 15:13, 11:5 and 3:2 stay zero
    localparam logic [31:0] SCG_GATE_MASK = 32'h0707_1013;
    localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0000;

    localparam int unsigned SCG_COMPARATOR2_GATE_BIT = 26;
    localparam int unsigned SCG_COMPARATOR1_GATE_BIT = 25;
    localparam int unsigned SCG_COMPARATOR0_GATE_BIT = 24;
    localparam int unsigned SCG_TMR2_BIT = 18;
    localparam int unsigned SCG_TMR1_BIT = 17;
    localparam int unsigned SCG_TMR0_BIT = 16;
    localparam int unsigned SCG_TWI_BIT = 12;
    localparam int unsigned SCG_SSU_BIT = 4;
    localparam int unsigned SCG_ASU1_BIT = 1;
    localparam int unsigned SCG_ASU0_BIT = 0;

    // Unit index k is controlled by gate bit SCG_UNIT_BIT[k]
    localparam int unsigned SCG_UNIT_BIT [0:SCG_UNITS-1] = '{
        SCG_ASU0_BIT, SCG_ASU1_BIT, SCG_SSU_BIT, SCG_TWI_BIT, SCG_TMR0_BIT,
        SCG_TMR1_BIT, SCG_TMR2_BIT, SCG_COMPARATOR0_GATE_BIT, SCG_COMPARATOR1_GATE_BIT, SCG_COMPARATOR2_GATE_BIT
    };

    localparam int unsigned SCG_EV_W = 2;
    localparam int unsigned SCG_EV_FAULT = 0;
    localparam int unsigned SCG_EV_SWITCH = 1;
    localparam logic [SCG_EV_W-1:0] SCG_EV_RESET = 2'h0;

    typedef enum logic [1:0] {
        SCG_SRC_RUN,
        SCG_SRC_SLEEP,
        SCG_SRC_DEEP
    } scg_src_t;
endpackage

//--- logic/scg_gate_cell.sv
`timescale 1ns/10ps
module scg_gate_cell (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_next_en,
    input wire logic i_access,
    output logic o_clk_en,
    output logic o_fault,
    output logic o_changed
);
    // Apart from asynchronous reset, enable moves only on a clock edge, so a downstream gate never sees a runt while running
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_clk_en <= 1'b0;
        end else begin
            o_clk_en <= i_next_en;
        end
    end

    assign o_fault = i_access & ~o_clk_en;
    assign o_changed = i_next_en ^ o_clk_en;
endmodule

//--- logic/scg_clock_gate.sv
`timescale 1ns/10ps
// Functional notes
// - A set gate bit clocks its unit and a clear bit stops the clock and holds the unit off.
// - Any access to a unit whose clock is off ends with a bus fault instead of completing.
// - Reset clears every gate bit of both low-power registers, leaving all units off.
// - Gating follows the run register while running, sleep register in Sleep, deep in Deep-Sleep.
// - The low-power registers govern only while the auto gating select bit is set.
// - The sleep register decodes at offset 0x114 and the deep-sleep one at 0x124.
// - Bits 26, 25 and 24 gate comparators 2, 1 and 0.
// - Bits 18, 17 and 16 gate general counters 2, 1 and 0.
// - Bit 12 gates the two-wire unit.
// - Bit 4 gates the synchronous serial unit.
// - Bits 1 and 0 gate asynchronous serial units 1 and 0.
// - Reserved bits are read-only zero and software writes back what it read.
module scg_clock_gate (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [scg_pkg::SCG_ADDR_W-1:0] i_paddr,
    input wire logic [scg_pkg::SCG_DATA_W-1:0] i_pwdata,
    output logic [scg_pkg::SCG_DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [31:0] i_run_peripheral_clock_gate,
    input wire logic i_auto_gating_select,
    input wire logic i_sleep,
    input wire logic i_deep_sleep,
    input wire logic [scg_pkg::SCG_UNITS-1:0] i_unit_access,
    output logic [scg_pkg::SCG_UNITS-1:0] o_unit_clk_en,
    output logic [scg_pkg::SCG_UNITS-1:0] o_unit_fault,
    output logic o_irq
);
    import scg_pkg::*;

    logic [31:0] sleep_peripheral_clock_gate;
    logic [31:0] deep_sleep_peripheral_clock_gate;
    logic [SCG_EV_W-1:0] irq_status;
    logic [SCG_EV_W-1:0] irq_mask;
    logic [31:0] active_gate;
    logic [SCG_UNITS-1:0] next_unit_en;
    logic [SCG_UNITS-1:0] unit_changed;
    logic [SCG_EV_W-1:0] event_set;
    logic [SCG_EV_W-1:0] status_clr;
    logic [31:0] next_prdata;
    scg_src_t src;
    logic setup;
    logic access;
    logic wr_en;
    logic hit_sleep;
    logic hit_deep;
    logic hit_status;
    logic hit_mask;
    logic mapped;

    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable;
    assign hit_sleep = (i_paddr == SCG_SLEEP_OFS);
    assign hit_deep = (i_paddr == SCG_DEEP_OFS);
    assign hit_status = (i_paddr == SCG_STATUS_OFS);
    assign hit_mask = (i_paddr == SCG_MASK_OFS);
    assign mapped = hit_sleep | hit_deep | hit_status | hit_mask;

    // Read data is captured in the setup cycle so the access phase never waits
    assign o_pready = 1'b1;
    assign o_pslverr = access & ~mapped;
    assign wr_en = access & i_pwrite & mapped;

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_sleep) begin
            next_prdata = sleep_peripheral_clock_gate & SCG_GATE_MASK;
        end else if (hit_deep) begin
            next_prdata = deep_sleep_peripheral_clock_gate & SCG_GATE_MASK;
        end else if (hit_status) begin
            next_prdata = {{(32-SCG_EV_W){1'b0}}, irq_status};
        end else if (hit_mask) begin
            next_prdata = {{(32-SCG_EV_W){1'b0}}, irq_mask};
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata <= 32'h0000_0000;
        end else if (setup && !i_pwrite) begin
            o_prdata <= next_prdata;
        end
    end

    // Reserved positions are masked off at the write so they can never read back one
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sleep_peripheral_clock_gate <= SCG_GATE_RESET;
        end else if (wr_en && hit_sleep) begin
            sleep_peripheral_clock_gate <= i_pwdata & SCG_GATE_MASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            deep_sleep_peripheral_clock_gate <= SCG_GATE_RESET;
        end else if (wr_en && hit_deep) begin
            deep_sleep_peripheral_clock_gate <= i_pwdata & SCG_GATE_MASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_mask <= SCG_EV_RESET;
        end else if (wr_en && hit_mask) begin
            irq_mask <= i_pwdata[SCG_EV_W-1:0];
        end
    end

    // Deep-Sleep outranks Sleep if the power controller ever raises both
    always_comb begin
        src = SCG_SRC_RUN;
        if (i_auto_gating_select) begin
            if (i_deep_sleep) begin
                src = SCG_SRC_DEEP;
            end else if (i_sleep) begin
                src = SCG_SRC_SLEEP;
            end
        end
    end

    always_comb begin
        case (src)
            SCG_SRC_RUN: active_gate = i_run_peripheral_clock_gate;
            SCG_SRC_SLEEP: active_gate = sleep_peripheral_clock_gate;
            SCG_SRC_DEEP: active_gate = deep_sleep_peripheral_clock_gate;
            default: active_gate = i_run_peripheral_clock_gate;
        endcase
    end

    // One cell per controlled unit; a clear bit stops the clock and faults accesses
    genvar k;
    generate
        for (k = 0; k < SCG_UNITS; k++) begin : g_unit
            assign next_unit_en[k] = active_gate[SCG_UNIT_BIT[k]];
            scg_gate_cell u_cell (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_next_en(next_unit_en[k]),
                .i_access(i_unit_access[k]),
                .o_clk_en(o_unit_clk_en[k]),
                .o_fault(o_unit_fault[k]),
                .o_changed(unit_changed[k])
            );
        end
    endgenerate

    assign event_set[SCG_EV_FAULT] = |o_unit_fault;
    assign event_set[SCG_EV_SWITCH] = |unit_changed;
    assign status_clr = (wr_en && hit_status) ? i_pwdata[SCG_EV_W-1:0] : SCG_EV_RESET;

    // A new event in the clearing cycle survives the write of one
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_status <= SCG_EV_RESET;
        end else begin
            irq_status <= (irq_status & ~status_clr) | event_set;
        end
    end

    assign o_irq = |(irq_status & irq_mask);

    sequence s_sleep_write;
        access && i_pwrite && hit_sleep;
    endsequence

    sequence s_deep_write;
        access && i_pwrite && hit_deep;
    endsequence

    sequence s_hold_sleep_auto;
        i_auto_gating_select && i_sleep && !i_deep_sleep;
    endsequence

    sequence s_status_write;
        access && i_pwrite && hit_status;
    endsequence

    sequence s_read_setup;
        setup && !i_pwrite;
    endsequence

    sequence s_unmapped_access;
        access && !mapped;
    endsequence

    property p_sleep_stored;
        logic [31:0] d;
        @(posedge i_clk) disable iff (!i_rstn)
        (s_sleep_write, d = i_pwdata) |=> (sleep_peripheral_clock_gate == (d & SCG_GATE_MASK));
    endproperty

    property p_deep_stored;
        logic [31:0] d;
        @(posedge i_clk) disable iff (!i_rstn)
        (s_deep_write, d = i_pwdata) |=> (deep_sleep_peripheral_clock_gate == (d & SCG_GATE_MASK));
    endproperty

    sleep_write_a: assert property (p_sleep_stored)
        else $error("sleep gate write not stored");

    deep_write_a: assert property (p_deep_stored)
        else $error("deep-sleep gate write not stored");

    reserved_zero_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        ((sleep_peripheral_clock_gate | deep_sleep_peripheral_clock_gate) & ~SCG_GATE_MASK) == 0)
        else $error("reserved gate bit became set");

    run_follow_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (!i_sleep && !i_deep_sleep) ##1 (!i_sleep && !i_deep_sleep)
        |-> o_unit_clk_en[0] == $past(i_run_peripheral_clock_gate[0]))
        else $error("run gating not applied while running");

    sleep_comp_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        s_hold_sleep_auto |=> o_unit_clk_en[9:7] == $past(sleep_peripheral_clock_gate[26:24]))
        else $error("comparator gating not from sleep register");

    deep_counter_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_auto_gating_select && i_deep_sleep)
        |=> o_unit_clk_en[6:4] == $past(deep_sleep_peripheral_clock_gate[18:16]))
        else $error("counter gating not from deep-sleep register");

    no_auto_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (!i_auto_gating_select && i_deep_sleep)
        |=> o_unit_clk_en[3:2] == $past({i_run_peripheral_clock_gate[12],
                                         i_run_peripheral_clock_gate[4]}))
        else $error("low-power gating used without auto gating");

    serial_map_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        s_hold_sleep_auto |=> o_unit_clk_en[1:0] == $past(sleep_peripheral_clock_gate[1:0]))
        else $error("serial unit gating bits mismatched");

    gated_fault_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        |(i_unit_access & ~o_unit_clk_en) |-> (|o_unit_fault) ##1 irq_status[SCG_EV_FAULT])
        else $error("access to stopped unit not faulted");

    stopped_quiet_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (next_unit_en == 0) [*2] |-> (o_unit_clk_en == 0) && (o_unit_fault == i_unit_access))
        else $error("stopped unit still enabled");

    reset_off_a: assert property (
        @(posedge i_clk)
        !i_rstn |-> (o_unit_clk_en == 0) && (sleep_peripheral_clock_gate == 0)
                    && (deep_sleep_peripheral_clock_gate == 0))
        else $error("gates not cleared in reset");

    unmapped_error_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        s_unmapped_access |-> o_pslverr)
        else $error("unmapped access not refused");

    sleep_read_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (s_read_setup ##0 hit_sleep)
        |=> o_prdata == $past(sleep_peripheral_clock_gate))
        else $error("sleep gate read data wrong");

    deep_read_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (s_read_setup ##0 hit_deep)
        |=> o_prdata == $past(deep_sleep_peripheral_clock_gate))
        else $error("deep-sleep gate read data wrong");

    read_reserved_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        s_read_setup |=> (o_prdata & ~SCG_GATE_MASK) == 32'h0000_0000)
        else $error("reserved bit read back as one");

    unmapped_write_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (s_unmapped_access ##0 i_pwrite)
        |=> $stable(sleep_peripheral_clock_gate)
            && $stable(deep_sleep_peripheral_clock_gate))
        else $error("unmapped write changed a gate register");

    gate_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !(access && i_pwrite)
        |=> $stable(sleep_peripheral_clock_gate)
            && $stable(deep_sleep_peripheral_clock_gate))
        else $error("gate register moved without a write");

    deep_over_sleep_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_auto_gating_select && i_deep_sleep && i_sleep)
        |=> o_unit_clk_en[3:0] == $past({deep_sleep_peripheral_clock_gate[12],
                                         deep_sleep_peripheral_clock_gate[4],
                                         deep_sleep_peripheral_clock_gate[1:0]}))
        else $error("sleep gating outranked deep-sleep gating");

    sleep_counter_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        s_hold_sleep_auto
        |=> o_unit_clk_en[6:4] == $past(sleep_peripheral_clock_gate[18:16]))
        else $error("counter gating not from sleep register");

    sleep_two_wire_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        s_hold_sleep_auto |=> o_unit_clk_en[3] == $past(sleep_peripheral_clock_gate[12]))
        else $error("two-wire gating not from sleep register");

    deep_sync_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_auto_gating_select && i_deep_sleep)
        |=> o_unit_clk_en[2] == $past(deep_sleep_peripheral_clock_gate[4]))
        else $error("sync serial gating not from deep-sleep register");

    deep_comp_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_auto_gating_select && i_deep_sleep)
        |=> o_unit_clk_en[9:7] == $past(deep_sleep_peripheral_clock_gate[26:24]))
        else $error("comparator gating not from deep-sleep register");

    deep_serial_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_auto_gating_select && i_deep_sleep)
        |=> o_unit_clk_en[1:0] == $past(deep_sleep_peripheral_clock_gate[1:0]))
        else $error("serial gating not from deep-sleep register");

    run_all_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !i_auto_gating_select
        |=> o_unit_clk_en == $past({i_run_peripheral_clock_gate[26:24],
                                    i_run_peripheral_clock_gate[18:16],
                                    i_run_peripheral_clock_gate[12],
                                    i_run_peripheral_clock_gate[4],
                                    i_run_peripheral_clock_gate[1:0]}))
        else $error("run gating not kept without auto gating");

    fault_only_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (o_unit_fault & (o_unit_clk_en | ~i_unit_access)) == {SCG_UNITS{1'b0}})
        else $error("fault raised for a clocked or idle unit");

    status_clear_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (s_status_write ##0 (event_set == SCG_EV_RESET))
        |=> (irq_status & $past(i_pwdata[SCG_EV_W-1:0])) == SCG_EV_RESET)
        else $error("status bit not cleared by write of one");

    switch_event_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_rstn && (next_unit_en != o_unit_clk_en)) |=> irq_status[SCG_EV_SWITCH])
        else $error("enable change not recorded");
endmodule

//--- testbench/sleep_clock_gating_group1_test.sv
`timescale 1ns/10ps
module sleep_clock_gating_group1_test;
    import scg_pkg::*;
    logic clk;
    logic rstn;
    logic psel;
    logic pen;
    logic pwr;
    logic [SCG_ADDR_W-1:0] paddr;
    logic [SCG_DATA_W-1:0] pwdata;
    logic [SCG_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] run_gate;
    logic auto_sel;
    logic slp;
    logic dp;
    logic [SCG_UNITS-1:0] acc;
    logic [SCG_UNITS-1:0] clk_en;
    logic [SCG_UNITS-1:0] fault;
    logic irq;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    // Bit positions are spelled out here rather than taken from the package map
    localparam int unsigned POS [0:9] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};

    scg_clock_gate u_scg_clock_gate (.i_clk(clk), .i_rstn(rstn), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_run_peripheral_clock_gate(run_gate), .i_auto_gating_select(auto_sel),
        .i_sleep(slp), .i_deep_sleep(dp), .i_unit_access(acc),
        .o_unit_clk_en(clk_en), .o_unit_fault(fault), .o_irq(irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        // Whole run needs well under a thousand cycles
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic gate_mode(input logic a, input logic s, input logic d, input logic [31:0] r);
        @(posedge clk);
        auto_sel <= a;
        slp <= s;
        dp <= d;
        run_gate <= r;
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        rstn <= 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = '0;
        pwdata = '0;
        run_gate = '0;
        auto_sel = 1'b0;
        slp = 1'b0;
        dp = 1'b0;
        acc = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rdchk(SCG_SLEEP_OFS, 32'h0000_0000);
        chk(32'(err), 32'h0);
        chk(32'(pready), 32'h1);
        rdchk(SCG_DEEP_OFS, 32'h0000_0000);
        chk(32'(clk_en), 32'h0);
        apb(1'b1, 12'h114, 32'hffff_ffff);
        rdchk(12'h114, 32'h0707_1013);
        apb(1'b1, 12'h124, 32'hffff_ffff);
        rdchk(12'h124, 32'h0707_1013);
        gate_mode(1'b1, 1'b1, 1'b0, 32'h0);
        @(posedge clk);
        acc <= '1;
        // Walk one enable through each unit; deep register is all ones and must not leak in
        for (int k = 0; k < 10; k++) begin
            apb(1'b1, SCG_SLEEP_OFS, 32'h1 << POS[k]);
            repeat (2) @(posedge clk);
            #1;
            chk(32'(clk_en), 32'h1 << k);
            chk(32'(fault), 32'h3ff ^ (32'h1 << k));
        end
        @(posedge clk);
        acc <= '0;
        gate_mode(1'b1, 1'b1, 1'b1, 32'h0);
        chk(32'(clk_en), 32'h3ff);
        apb(1'b1, SCG_DEEP_OFS, 32'h0100_0010);
        gate_mode(1'b1, 1'b1, 1'b1, 32'h0);
        chk(32'(clk_en), 32'h084);
        gate_mode(1'b0, 1'b1, 1'b1, 32'h0000_0013);
        chk(32'(clk_en), 32'h007);
        gate_mode(1'b1, 1'b0, 1'b0, 32'h0404_0000);
        chk(32'(clk_en), 32'h240);
        apb(1'b1, SCG_STATUS_OFS, 32'h3);
        @(posedge clk);
        acc <= 10'h001;
        @(posedge clk);
        #1;
        chk(32'(fault), 32'h001);
        @(posedge clk);
        acc <= 10'h000;
        rdchk(SCG_STATUS_OFS, 32'h1);
        chk(32'(irq), 32'h0);
        apb(1'b1, SCG_MASK_OFS, 32'h1);
        #1;
        chk(32'(irq), 32'h1);
        apb(1'b1, SCG_STATUS_OFS, 32'h1);
        #1;
        chk(32'(irq), 32'h0);
        rdchk(SCG_MASK_OFS, 32'h1);
        // Unmapped place: refused, nothing stored, reads zero
        apb(1'b1, 12'h200, 32'hffff_ffff);
        chk(32'(err), 32'h1);
        rdchk(12'h200, 32'h0);
        chk(32'(err), 32'h1);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdchk(SCG_DEEP_OFS, 32'h0);
        rdchk(SCG_SLEEP_OFS, 32'h0);
        tally_and_finish();
    end
endmodule
